// [core/pfc_pkg.sv]
// Package: register map, field layout and carrier types for the fan loop
// ============================================================
// Functional notes
// - Hysteresis low nibble, half-degree steps
// - Minimum duty high nibble, 6.25 percent steps
// - Hold hottest zone within target minus hysteresis
// - Targets use temperature encoding, reset zero
// - Off temperature 80h disables, default
// - Reaching off temperature forces zero duty
// - Integral exponent bits 1:0, signed
// - Proportional exponent bits 3:2, upper reserved
// - Read-only maker identification, writes ignored
// - Binding bits pick zone 1/2 inputs
// - Binding bits route loop to fan outputs
`default_nettype none

package pfc_pkg;

    // ============================================================
    // Register offsets
    localparam logic [7:0] ADDR_BINDINGS = 8'h35;
    localparam logic [7:0] ADDR_MIN_DUTY_HYST = 8'h36;
    localparam logic [7:0] ADDR_ZONE1_TARGET = 8'h37;
    localparam logic [7:0] ADDR_ZONE2_TARGET = 8'h38;
    localparam logic [7:0] ADDR_ZONE1_OFF = 8'h39;
    localparam logic [7:0] ADDR_ZONE2_OFF = 8'h3a;
    localparam logic [7:0] ADDR_P_MANTISSA = 8'h3b;
    localparam logic [7:0] ADDR_I_MANTISSA = 8'h3c;
    localparam logic [7:0] ADDR_EXPONENTS = 8'h3d;
    localparam logic [7:0] ADDR_MAKER_ID = 8'h3e;

    // ============================================================
    // Reset values
    localparam logic [7:0] RST_BINDINGS = 8'h30;
    localparam logic [7:0] RST_MIN_DUTY_HYST = 8'h00;
    localparam logic [7:0] RST_TARGET = 8'h00;
    localparam logic [7:0] RST_OFF = 8'h80;
    localparam logic [7:0] RST_MANTISSA = 8'h00;
    localparam logic [3:0] RST_EXPONENTS = 4'h0;
    // Arbitrary neutral value, not any real maker's code
    localparam logic [7:0] MAKER_ID_VALUE = 8'h5a;

    // ============================================================
    // Field positions and codes
    localparam int HYST_LSB = 0;
    localparam int MIN_DUTY_LSB = 4;
    localparam int ICE_LSB = 0;
    localparam int PCE_LSB = 2;
    localparam int BIND_ZONE1 = 0;
    localparam int BIND_ZONE2 = 1;
    localparam int BIND_FAN1 = 2;
    localparam int BIND_FAN2 = 3;
    localparam logic [7:0] OFF_DISABLED = 8'h80;
    localparam logic [1:0] EXP_MINUS2 = 2'h2;
    localparam logic [1:0] EXP_MINUS1 = 2'h3;
    localparam logic [1:0] EXP_PLUS1 = 2'h1;
    localparam logic [7:0] DUTY_MAX = 8'hff;
    localparam logic [7:0] DUTY_ZERO = 8'h00;

    // ============================================================
    // Carriers
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } pfc_reg_req_t;

    typedef struct packed {
        logic [7:0] bindings;
        logic [7:0] min_duty_hyst;
        logic [7:0] zone1_target;
        logic [7:0] zone2_target;
        logic [7:0] zone1_off;
        logic [7:0] zone2_off;
        logic [7:0] p_mantissa;
        logic [7:0] i_mantissa;
        logic [3:0] exponents;
        logic [7:0] rdata;
        logic hit;
        logic [7:0] integral;
        logic [7:0] loop_duty;
        logic forced_off;
        logic [7:0] fan1_duty;
        logic [7:0] fan2_duty;
    } pfc_state_t;

endpackage : pfc_pkg

`default_nettype wire

// [core/pfc_fan_loop.sv]
// Module: fan loop configuration registers and proportional/integral loop
`default_nettype none

module pfc_fan_loop (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire pfc_pkg::pfc_reg_req_t reg_req_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_hit_out,
    input wire logic sample_in,
    input wire logic [7:0] zone1_temp_in,
    input wire logic [7:0] zone2_temp_in,
    input wire logic [7:0] lut1_duty_in,
    input wire logic [7:0] lut2_duty_in,
    output logic [7:0] fan1_duty_out,
    output logic [7:0] fan2_duty_out,
    output logic loop_forced_off_out
);

    pfc_pkg::pfc_state_t st_ff;
    pfc_pkg::pfc_state_t nxt_st;

    // ============================================================
    // Gain scaling
    function automatic logic signed [21:0] pfc_scale(
        input logic [7:0] mant,
        input logic signed [10:0] err,
        input logic [1:0] expo
    );
        logic signed [21:0] mm;
        logic signed [21:0] ee;
        logic signed [21:0] prod;
        mm = 22'($signed({1'b0, mant}));
        ee = 22'(err);
        prod = mm * ee;
        // Exponent is a two-bit signed power of two
        case (expo)
            pfc_pkg::EXP_MINUS2: pfc_scale = prod >>> 2;
            pfc_pkg::EXP_MINUS1: pfc_scale = prod >>> 1;
            pfc_pkg::EXP_PLUS1: pfc_scale = prod <<< 1;
            default: pfc_scale = prod;
        endcase
    endfunction : pfc_scale

    // ============================================================
    // Next state
    logic use_z1;
    logic use_z2;
    logic signed [7:0] hot;
    logic [7:0] tgt;
    logic signed [10:0] t_half;
    logic signed [10:0] hi_half;
    logic signed [10:0] lo_half;
    logic signed [10:0] err;
    logic signed [21:0] acc_sum;
    logic signed [21:0] out_sum;
    logic [7:0] acc_clip;
    logic [7:0] min_duty;
    logic [7:0] duty_new;
    logic [7:0] ch_temp [2];
    logic [7:0] ch_lut [2];
    logic [7:0] ch_off_lim [2];
    logic ch_off [2];
    logic [7:0] ch_fan [2];

    // ============================================================
    // Per-channel off check and fan source select
    assign ch_temp[0] = zone1_temp_in;
    assign ch_temp[1] = zone2_temp_in;
    assign ch_lut[0] = lut1_duty_in;
    assign ch_lut[1] = lut2_duty_in;
    assign ch_off_lim[0] = st_ff.zone1_off;
    assign ch_off_lim[1] = st_ff.zone2_off;

    for (genvar k = 0; k < 2; k++)
    begin : g_chan
        logic zone_bound;
        logic fan_bound;
        logic off_armed;
        assign zone_bound = st_ff.bindings[pfc_pkg::BIND_ZONE1 + k];
        assign fan_bound = st_ff.bindings[pfc_pkg::BIND_FAN1 + k];
        // 80h is the coldest reading, so it is free as a switch
        assign off_armed = ch_off_lim[k] != pfc_pkg::OFF_DISABLED;
        // Unbound zones never shut the loop off
        assign ch_off[k] = zone_bound && off_armed
            && ($signed(ch_temp[k]) >= $signed(ch_off_lim[k]));
        // Bound fans share the one loop duty; an unbound fan takes its LUT duty
        assign ch_fan[k] = fan_bound ? st_ff.loop_duty : ch_lut[k];
    end

    // ============================================================
    // Loop and register update
    always_comb
    begin
        nxt_st = st_ff;
        // ========================================================
        // Zone choice
        use_z1 = st_ff.bindings[pfc_pkg::BIND_ZONE1];
        use_z2 = st_ff.bindings[pfc_pkg::BIND_ZONE2];
        // Hottest of the bound zones steers the loop
        if (use_z1 && (!use_z2 ||
            $signed(zone1_temp_in) >= $signed(zone2_temp_in)))
        begin
            hot = $signed(zone1_temp_in);
            tgt = st_ff.zone1_target;
        end
        else
        begin
            hot = $signed(zone2_temp_in);
            tgt = st_ff.zone2_target;
        end
        // ========================================================
        // Error band
        // Work in half degrees so hysteresis steps stay exact
        t_half = 11'($signed({hot, 1'b0}));
        hi_half = 11'($signed({tgt, 1'b0}));
        lo_half = hi_half - 11'({1'b0,
            st_ff.min_duty_hyst[pfc_pkg::HYST_LSB +: 4]});
        if (!use_z1 && !use_z2)
        begin
            err = '0;
        end
        else if (t_half > hi_half)
        begin
            err = t_half - hi_half;
        end
        else if (t_half < lo_half)
        begin
            err = t_half - lo_half;
        end
        else
        begin
            err = '0;
        end
        // ========================================================
        // Integral term
        acc_sum = 22'($signed({1'b0, st_ff.integral}))
            + pfc_scale(st_ff.i_mantissa, err,
                st_ff.exponents[pfc_pkg::ICE_LSB +: 2]);
        // Integral is clipped to duty range to stop windup
        if (acc_sum < 0)
        begin
            acc_clip = pfc_pkg::DUTY_ZERO;
        end
        else if (acc_sum > $signed(22'(pfc_pkg::DUTY_MAX)))
        begin
            acc_clip = pfc_pkg::DUTY_MAX;
        end
        else
        begin
            acc_clip = acc_sum[7:0];
        end
        // ========================================================
        // Proportional term and duty floor
        out_sum = 22'($signed({1'b0, acc_clip}))
            + pfc_scale(st_ff.p_mantissa, err,
                st_ff.exponents[pfc_pkg::PCE_LSB +: 2]);
        min_duty = {st_ff.min_duty_hyst[pfc_pkg::MIN_DUTY_LSB +: 4],
            4'h0};
        // Signed compare, so a large negative term floors
        if (out_sum < $signed(22'(min_duty)))
        begin
            duty_new = min_duty;
        end
        else if (out_sum > $signed(22'(pfc_pkg::DUTY_MAX)))
        begin
            duty_new = pfc_pkg::DUTY_MAX;
        end
        else
        begin
            duty_new = out_sum[7:0];
        end
        // ========================================================
        // Loop update on sample
        if (sample_in)
        begin
            if (ch_off[0] || ch_off[1])
            begin
                nxt_st.loop_duty = pfc_pkg::DUTY_ZERO;
                // Integral restarts from zero after a forced stop
                nxt_st.integral = pfc_pkg::DUTY_ZERO;
                nxt_st.forced_off = 1'b1;
            end
            else
            begin
                nxt_st.loop_duty = duty_new;
                nxt_st.integral = acc_clip;
                nxt_st.forced_off = 1'b0;
            end
        end

        // ========================================================
        // Fan outputs
        nxt_st.fan1_duty = ch_fan[0];
        nxt_st.fan2_duty = ch_fan[1];

        // ========================================================
        // Register writes; identification stays fixed
        if (reg_req_in.wr)
        begin
            case (reg_req_in.addr)
                pfc_pkg::ADDR_BINDINGS:
                    nxt_st.bindings = reg_req_in.wdata;
                pfc_pkg::ADDR_MIN_DUTY_HYST:
                    nxt_st.min_duty_hyst = reg_req_in.wdata;
                pfc_pkg::ADDR_ZONE1_TARGET:
                    nxt_st.zone1_target = reg_req_in.wdata;
                pfc_pkg::ADDR_ZONE2_TARGET:
                    nxt_st.zone2_target = reg_req_in.wdata;
                pfc_pkg::ADDR_ZONE1_OFF:
                    nxt_st.zone1_off = reg_req_in.wdata;
                pfc_pkg::ADDR_ZONE2_OFF:
                    nxt_st.zone2_off = reg_req_in.wdata;
                pfc_pkg::ADDR_P_MANTISSA:
                    nxt_st.p_mantissa = reg_req_in.wdata;
                pfc_pkg::ADDR_I_MANTISSA:
                    nxt_st.i_mantissa = reg_req_in.wdata;
                pfc_pkg::ADDR_EXPONENTS:
                    nxt_st.exponents = reg_req_in.wdata[3:0];
                pfc_pkg::ADDR_MAKER_ID:
                begin
                    // Identification is fixed; the write is dropped
                    nxt_st.hit = st_ff.hit;
                end
                default:
                begin
                    // Unmapped writes vanish silently
                    nxt_st.hit = st_ff.hit;
                end
            endcase
        end

        // ========================================================
        // Register reads, one cycle latency
        // Beside a write, a read returns the old value
        if (reg_req_in.rd)
        begin
            nxt_st.hit = 1'b1;
            case (reg_req_in.addr)
                pfc_pkg::ADDR_BINDINGS: nxt_st.rdata = st_ff.bindings;
                pfc_pkg::ADDR_MIN_DUTY_HYST:
                    nxt_st.rdata = st_ff.min_duty_hyst;
                pfc_pkg::ADDR_ZONE1_TARGET:
                    nxt_st.rdata = st_ff.zone1_target;
                pfc_pkg::ADDR_ZONE2_TARGET:
                    nxt_st.rdata = st_ff.zone2_target;
                pfc_pkg::ADDR_ZONE1_OFF: nxt_st.rdata = st_ff.zone1_off;
                pfc_pkg::ADDR_ZONE2_OFF: nxt_st.rdata = st_ff.zone2_off;
                pfc_pkg::ADDR_P_MANTISSA: nxt_st.rdata = st_ff.p_mantissa;
                pfc_pkg::ADDR_I_MANTISSA: nxt_st.rdata = st_ff.i_mantissa;
                pfc_pkg::ADDR_EXPONENTS:
                    nxt_st.rdata = {4'h0, st_ff.exponents};
                pfc_pkg::ADDR_MAKER_ID:
                    nxt_st.rdata = pfc_pkg::MAKER_ID_VALUE;
                default:
                begin
                    nxt_st.rdata = 8'h00;
                    nxt_st.hit = 1'b0;
                end
            endcase
        end
    end

    // ============================================================
    // State register
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            st_ff.bindings <= pfc_pkg::RST_BINDINGS;
            st_ff.min_duty_hyst <= pfc_pkg::RST_MIN_DUTY_HYST;
            st_ff.zone1_target <= pfc_pkg::RST_TARGET;
            st_ff.zone2_target <= pfc_pkg::RST_TARGET;
            st_ff.zone1_off <= pfc_pkg::RST_OFF;
            st_ff.zone2_off <= pfc_pkg::RST_OFF;
            st_ff.p_mantissa <= pfc_pkg::RST_MANTISSA;
            st_ff.i_mantissa <= pfc_pkg::RST_MANTISSA;
            st_ff.exponents <= pfc_pkg::RST_EXPONENTS;
            st_ff.rdata <= 8'h00;
            st_ff.hit <= 1'b0;
            st_ff.integral <= pfc_pkg::DUTY_ZERO;
            st_ff.loop_duty <= pfc_pkg::DUTY_ZERO;
            st_ff.forced_off <= 1'b0;
            st_ff.fan1_duty <= pfc_pkg::DUTY_ZERO;
            st_ff.fan2_duty <= pfc_pkg::DUTY_ZERO;
        end
        // Low enable freezes every register
        else if (ce_in)
        begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata_out = st_ff.rdata;
    assign reg_hit_out = st_ff.hit;
    assign fan1_duty_out = st_ff.fan1_duty;
    assign fan2_duty_out = st_ff.fan2_duty;
    assign loop_forced_off_out = st_ff.forced_off;

endmodule : pfc_fan_loop

`default_nettype wire

// [testbench/pfc_fan_loop_asserts.sv]
// Checker for the fan loop register and loop ports
`default_nettype none
module pfc_fan_loop_chk (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire pfc_pkg::pfc_reg_req_t reg_req_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic reg_hit_out,
    input wire logic sample_in,
    input wire logic [7:0] zone1_temp_in,
    input wire logic [7:0] zone2_temp_in,
    input wire logic [7:0] lut1_duty_in,
    input wire logic [7:0] lut2_duty_in,
    input wire logic [7:0] fan1_duty_out,
    input wire logic [7:0] fan2_duty_out,
    input wire logic loop_forced_off_out
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clock_in);
    endclocking
    default disable iff (rst_in);
    // ========================================
    // Shadow of written bytes; ports hide the real ones
    logic [7:0] bnd_ff, off1_ff, mind_ff;
    logic rd_ok, st;
    assign rd_ok = ce_in && reg_req_in.rd;
    assign st = ce_in && sample_in && !reg_req_in.wr;
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            bnd_ff <= 8'h30;
            off1_ff <= 8'h80;
            mind_ff <= 8'h00;
        end
        else if (ce_in && reg_req_in.wr)
            case (reg_req_in.addr)
                8'h35: bnd_ff <= reg_req_in.wdata;
                8'h36: mind_ff <= {reg_req_in.wdata[7:4], 4'h0};
                8'h39: off1_ff <= reg_req_in.wdata;
                default: ;
            endcase
    end
    // ========================================
    // Assertions
    a_maker_id_read: assert property (
        rd_ok && reg_req_in.addr == 8'h3e
        |=> reg_rdata_out == pfc_pkg::MAKER_ID_VALUE && reg_hit_out)
        else $error("maker id read wrong");
    a_exp_upper_zero: assert property (
        rd_ok && reg_req_in.addr == 8'h3d |=> reg_rdata_out[7:4] == 4'h0)
        else $error("exponent upper bits set");
    a_target_readback: assert property (
        (ce_in && reg_req_in.wr && !reg_req_in.rd
        && reg_req_in.addr == 8'h37) ##1 !(ce_in && reg_req_in.wr)
        ##1 (rd_ok && reg_req_in.addr == 8'h37)
        |=> reg_rdata_out == $past(reg_req_in.wdata, 3))
        else $error("target readback wrong");
    a_rdata_holds: assert property (
        !rd_ok |=> $stable(reg_rdata_out))
        else $error("read data moved without read");
    a_off_forces: assert property (
        st && bnd_ff[0] && off1_ff != 8'h80
        && $signed(zone1_temp_in) >= $signed(off1_ff) |=> loop_forced_off_out)
        else $error("off temperature not forced");
    a_off_disabled: assert property (
        st && !bnd_ff[1] && (!bnd_ff[0] || off1_ff == 8'h80)
        |=> !loop_forced_off_out)
        else $error("forced off while disabled");
    a_min_duty: assert property (
        st ##1 (ce_in && !reg_req_in.wr && bnd_ff[2] && !loop_forced_off_out)
        |=> fan1_duty_out >= $past(mind_ff, 2))
        else $error("duty below floor");
    a_fan_from_lut: assert property (
        (st && !bnd_ff[3]) ##1 (ce_in && !reg_req_in.wr)
        |=> fan2_duty_out == $past(lut2_duty_in))
        else $error("unbound fan not from fallback");
endmodule : pfc_fan_loop_chk

bind pfc_fan_loop pfc_fan_loop_chk chk (.clock_in(clock_in),
    .rst_in(rst_in), .ce_in(ce_in), .reg_req_in(reg_req_in),
    .reg_rdata_out(reg_rdata_out), .reg_hit_out(reg_hit_out),
    .sample_in(sample_in), .zone1_temp_in(zone1_temp_in),
    .zone2_temp_in(zone2_temp_in), .lut1_duty_in(lut1_duty_in),
    .lut2_duty_in(lut2_duty_in), .fan1_duty_out(fan1_duty_out),
    .fan2_duty_out(fan2_duty_out), .loop_forced_off_out(loop_forced_off_out));
`default_nettype wire

// [testbench/pfc_sensor_model.sv]
// Temperature sensors and fallback duty source beside the loop
`default_nettype none
module pfc_sensor_model (
    output logic [7:0] zone1_temp_out,
    output logic [7:0] zone2_temp_out,
    output logic [7:0] lut1_duty_out,
    output logic [7:0] lut2_duty_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] v [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
    assign zone1_temp_out = v[0];
    assign zone2_temp_out = v[1];
    assign lut1_duty_out = v[2];
    assign lut2_duty_out = v[3];
    // Called off the clock edge, so readings never race the sample
    task automatic set_all(input logic [7:0] a, b, c, d);
        v = '{a, b, c, d};
    endtask : set_all
endmodule : pfc_sensor_model
`default_nettype wire

// [testbench/tb.sv]
// Self-checking bench for the fan loop registers and loop
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic ce_in = 1'b1;
    logic sample_in = 1'b0;
    pfc_pkg::pfc_reg_req_t req = '0;
    logic [7:0] rdata, f1, f2, z1, z2, l1, l2;
    logic hit, foff;
    int n_mismatch = 0;
    int checks_done = 0;
    int seed = 95;
    int cyc = 0;
    logic [7:0] tg, hy, pm, pe, md, tp, lv;
    logic [7:0] rtab [10] = '{8'h30, 8'h00, 8'h00, 8'h00, 8'h80, 8'h80,
        8'h00, 8'h00, 8'h00, pfc_pkg::MAKER_ID_VALUE};
    logic [7:0] itab [4] = '{8'h20, 8'h40, 8'h08, 8'h10};
    pfc_sensor_model sens (.zone1_temp_out(z1), .zone2_temp_out(z2),
        .lut1_duty_out(l1), .lut2_duty_out(l2));
    pfc_fan_loop dut (.clock_in(clock_in), .rst_in(rst_in), .ce_in(ce_in),
        .reg_req_in(req), .reg_rdata_out(rdata), .reg_hit_out(hit),
        .sample_in(sample_in), .zone1_temp_in(z1), .zone2_temp_in(z2),
        .lut1_duty_in(l1), .lut2_duty_in(l2), .fan1_duty_out(f1),
        .fan2_duty_out(f2), .loop_forced_off_out(foff));
    initial forever #2.5 clock_in = ~clock_in;
    // ========================================
    // Tasks
    task automatic check(input string nm, input logic [7:0] s, e);
        checks_done++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("BAD %s exp %h seen %h", nm, e, s);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, d);
        req.addr = a;
        req.wdata = d;
        req.wr = 1'b1;
        @(negedge clock_in);
        req.wr = 1'b0;
        // Idle edge so no strobe is set twice at once
        @(negedge clock_in);
    endtask : wr
    task automatic rd(input logic [7:0] a, e, h);
        req.addr = a;
        req.rd = 1'b1;
        @(negedge clock_in);
        req.rd = 1'b0;
        check("rdata", rdata, e);
        check("hit", {7'h00, hit}, h);
        @(negedge clock_in);
    endtask : rd
    task automatic smp(input logic [7:0] a, b);
        lv = $random(seed);
        sens.set_all(a, b, ~lv, lv);
        sample_in = 1'b1;
        @(negedge clock_in);
        sample_in = 1'b0;
        repeat (2) @(negedge clock_in);
    endtask : smp
    function automatic logic [7:0] exp_duty(input int t, g, h, m, e, n);
        int r;
        r = (t > g) ? 2 * (t - g) : (2 * t < 2 * g - h) ? 2 * (t - g) + h : 0;
        r = m * r;
        r = (e == 2) ? r >>> 2 : (e == 3) ? r >>> 1 : (e == 1) ? r <<< 1 : r;
        r = (r < n * 16) ? n * 16 : (r > 255) ? 255 : r;
        return r[7:0];
    endfunction : exp_duty
    task automatic results();
        if (n_mismatch == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results
    always @(posedge clock_in)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_mismatch++;
            results();
        end
    end
    // ========================================
    // Main sequence
    initial
    begin
        repeat (12) @(posedge clock_in);
        @(negedge clock_in);
        rst_in = 1'b0;
        for (int a = 0; a < 10; a++)
            rd(8'h35 + a[7:0], rtab[a], 8'h01);
        rd(8'h40, 8'h00, 8'h00);
        wr(8'h3e, 8'ha5);
        rd(8'h3e, pfc_pkg::MAKER_ID_VALUE, 8'h01);
        wr(8'h3d, 8'hff);
        rd(8'h3d, 8'h0f, 8'h01);
        tp = $random(seed);
        wr(8'h37, tp);
        rd(8'h37, tp, 8'h01);
        ce_in = 1'b0;
        wr(8'h37, ~tp);
        ce_in = 1'b1;
        rd(8'h37, tp, 8'h01);
        wr(8'h35, 8'h05);
        for (int i = 0; i < 40; i++)
        begin
            tg = 8'h10 + ($random(seed) & 8'h3f);
            tp = tg - 8'h08 + ($random(seed) & 8'h0f);
            {md, hy, pm, pe} = $random(seed);
            wr(8'h36, {md[3:0], hy[3:0]});
            wr(8'h37, tg);
            wr(8'h3b, pm);
            wr(8'h3d, {4'h0, pe[1:0], 2'b00});
            smp(tp, $random(seed));
            check("fan1", f1, exp_duty(tp, tg, hy[3:0], pm, pe[1:0],
                md[3:0]));
            check("fan2", f2, lv);
            check("off", {7'h00, foff}, 8'h00);
        end
        wr(8'h3b, 8'h00);
        wr(8'h36, 8'h00);
        wr(8'h37, 8'h20);
        for (int e = 0; e < 4; e++)
        begin
            wr(8'h3c, 8'hff);
            smp(8'h00, 8'h00);
            wr(8'h3c, 8'h04);
            wr(8'h3d, e[7:0]);
            smp(8'h24, 8'h00);
            check("integ", f1, itab[e]);
        end
        wr(8'h39, 8'h28);
        for (int j = 0; j < 3; j++)
        begin
            smp(8'h27 + j[7:0], 8'h00);
            check("off", {7'h00, foff}, {7'h00, j > 0});
            if (j > 0)
                check("fan1", f1, 8'h00);
        end
        wr(8'h35, 8'h06);
        smp(8'h7f, 8'h00);
        check("off", {7'h00, foff}, 8'h00);
        wr(8'h35, 8'h05);
        wr(8'h39, 8'h80);
        smp(8'h7f, 8'h00);
        check("off", {7'h00, foff}, 8'h00);
        results();
    end
endmodule : tb
`default_nettype wire
